// >>> ppd_pkg.sv
/*
  Package for the PWM pin-pair and duty register slice: register
  offsets, field positions and reset values.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package ppd_pkg;
  localparam int unsigned PPD_NUM_PAIRS     = 4;
  localparam int unsigned PPD_ADDR_W        = 4;
  localparam int unsigned PPD_DUTY_W        = 16;
  localparam logic [3:0]  PPD_OFF_PIN_CTRL  = 4'h0;
  localparam logic [3:0]  PPD_OFF_DUTY_ONE  = 4'h4;
  localparam logic [3:0]  PPD_OFF_DUTY_TWO  = 4'h8;
  localparam logic [3:0]  PPD_OFF_PIN_DRIVE = 4'hC;
  localparam int unsigned PPD_LOW_EN_LSB    = 0;
  localparam int unsigned PPD_HIGH_EN_LSB   = 4;
  localparam int unsigned PPD_MODE_LSB      = 8;
  localparam logic [3:0]  PPD_MODE_RESET    = 4'h0;
  localparam logic [15:0] PPD_DUTY_RESET    = 16'h0000;
endpackage

// >>> ppd_pin_mux.sv
/*
  One output pair: complementary or independent shaping and pin
  ownership. Assumes the drive levels come from the register slice.
*/
`timescale 1ns/1ps
`default_nettype none
module ppd_pin_mux (
  // Configuration
  input  wire logic mode_indep,
  input  wire logic high_en,
  input  wire logic low_en,
  // Raw drive levels
  input  wire logic raw_high,
  input  wire logic raw_low,
  // Resolved pins
  output logic      pin_high,
  output logic      pin_low,
  output logic      pin_high_oe,
  output logic      pin_low_oe
);
  always_comb begin
    pin_high    = raw_high;
    pin_low     = mode_indep ? raw_low : ~raw_high;
    pin_high_oe = high_en;
    pin_low_oe  = low_en;
  end
endmodule // ppd_pin_mux
`default_nettype wire

// >>> ppd_pwm_pin_pair_duty_control.sv
/*
  Pin-pair configuration and duty-cycle registers of a four-pair PWM
  unit, as an APB slave. Assumes the time base and comparators live
  elsewhere and consume the duty values; pin levels come from a
  software-written drive register until that logic is attached.
*/
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ppd_pwm_pin_pair_duty_control
#(
  parameter int unsigned NUM_PAIRS = ppd_pkg::PPD_NUM_PAIRS
) (
  // Clock and reset
  input  wire logic                            pclk,
  input  wire logic                            presetn,
  input  wire logic                            clk_en,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [31:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // Power-on configuration
  input  wire logic                            pin_ownership_fuse,
  // Pins toward the power stage
  output logic      [NUM_PAIRS-1:0]            high_output_pin,
  output logic      [NUM_PAIRS-1:0]            low_output_pin,
  output logic      [NUM_PAIRS-1:0]            high_output_pin_oe,
  output logic      [NUM_PAIRS-1:0]            low_output_pin_oe,
  // Duty values to the comparator logic
  output logic      [ppd_pkg::PPD_DUTY_W-1:0]  duty_value_one,
  output logic      [ppd_pkg::PPD_DUTY_W-1:0]  duty_value_two
);
  import ppd_pkg::*;

  // Register fields are laid out for exactly four pairs
  if (NUM_PAIRS != PPD_NUM_PAIRS) begin : g_pairs_check
    $error("NUM_PAIRS must match the four-pair register layout");
  end

  // Register state; all software-visible except fuse_load_ff
  logic [3:0]  pair_mode_select_ff;
  logic [3:0]  high_pin_enable_ff;
  logic [3:0]  low_pin_enable_ff;
  logic [15:0] duty_one_ff;
  logic [15:0] duty_two_ff;
  logic [3:0]  drive_high_ff;
  logic [3:0]  drive_low_ff;
  logic        fuse_load_ff;
  // Bus decode and read path
  logic [31:0] nxt_prdata;
  logic        nxt_slverr;
  logic        setup_phase;
  logic        wr_access;
  logic        wr_pin_ctrl;
  logic        wr_duty_one;
  logic        wr_duty_two;
  logic        wr_pin_drive;
  // Per-pair shaper results, registered before the pins
  logic [3:0]  mux_high;
  logic [3:0]  mux_low;
  logic [3:0]  mux_high_oe;
  logic [3:0]  mux_low_oe;

  function automatic logic hit(input logic [31:0] a, input logic [3:0] off);
    hit = (a[31:PPD_ADDR_W] == '0) && (a[PPD_ADDR_W-1:0] == off);
  endfunction

  function automatic logic mapped(input logic [31:0] a);
    mapped = hit(a, PPD_OFF_PIN_CTRL) || hit(a, PPD_OFF_DUTY_ONE) ||
             hit(a, PPD_OFF_DUTY_TWO) || hit(a, PPD_OFF_PIN_DRIVE);
  endfunction

  // Writes land at the access edge, the one where the master sees ready;
  // landing at setup would let a write race the fuse load after reset
  assign setup_phase  = psel && !penable;
  assign wr_access    = clk_en && psel && penable && pready && pwrite &&
                        mapped(paddr);
  assign wr_pin_ctrl  = wr_access && hit(paddr, PPD_OFF_PIN_CTRL);
  assign wr_duty_one  = wr_access && hit(paddr, PPD_OFF_DUTY_ONE);
  assign wr_duty_two  = wr_access && hit(paddr, PPD_OFF_DUTY_TWO);
  assign wr_pin_drive = wr_access && hit(paddr, PPD_OFF_PIN_DRIVE);

  // Fuse sampled on the first enabled edge after release, not in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_load_ff <= 1'b1;
    end else if (clk_en) begin
      fuse_load_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_pin_enable_ff <= 4'h0;
      low_pin_enable_ff  <= 4'h0;
    end else if (clk_en && fuse_load_ff) begin
      // Fuse load wins over software for this single edge
      high_pin_enable_ff <= {4{pin_ownership_fuse}};
      low_pin_enable_ff  <= {4{pin_ownership_fuse}};
    end else if (wr_pin_ctrl && pstrb[0]) begin
      high_pin_enable_ff <= pwdata[PPD_HIGH_EN_LSB +: 4];
      low_pin_enable_ff  <= pwdata[PPD_LOW_EN_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_mode_select_ff <= PPD_MODE_RESET;
    end else if (wr_pin_ctrl && pstrb[1]) begin
      pair_mode_select_ff <= pwdata[PPD_MODE_LSB +: 4];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_one_ff <= PPD_DUTY_RESET;
    end else if (wr_duty_one) begin
      // Byte lanes let software change one half without a read
      if (pstrb[0]) duty_one_ff[7:0]  <= pwdata[7:0];
      if (pstrb[1]) duty_one_ff[15:8] <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_two_ff <= PPD_DUTY_RESET;
    end else if (wr_duty_two) begin
      if (pstrb[0]) duty_two_ff[7:0]  <= pwdata[7:0];
      if (pstrb[1]) duty_two_ff[15:8] <= pwdata[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_high_ff <= 4'h0;
      drive_low_ff  <= 4'h0;
    end else if (wr_pin_drive && pstrb[0]) begin
      // Stand-in levels until the time base drives the pairs
      drive_high_ff <= pwdata[7:4];
      drive_low_ff  <= pwdata[3:0];
    end
  end

  // One shaper per pair; enables pass straight to the pin owners
  genvar g;
  generate
    for (g = 0; g < NUM_PAIRS; g++) begin : g_pair
      ppd_pin_mux u_mux (
        .mode_indep  (pair_mode_select_ff[g]),
        .high_en     (high_pin_enable_ff[g]),
        .low_en      (low_pin_enable_ff[g]),
        .raw_high    (drive_high_ff[g]),
        .raw_low     (drive_low_ff[g]),
        .pin_high    (mux_high[g]),
        .pin_low     (mux_low[g]),
        .pin_high_oe (mux_high_oe[g]),
        .pin_low_oe  (mux_low_oe[g])
      );
    end
  endgenerate

  // Pins registered so outputs come straight from flip-flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_output_pin    <= '0;
      low_output_pin     <= '0;
      high_output_pin_oe <= '0;
      low_output_pin_oe  <= '0;
      duty_value_one     <= '0;
      duty_value_two     <= '0;
    end else if (clk_en) begin
      high_output_pin    <= mux_high;
      low_output_pin     <= mux_low;
      high_output_pin_oe <= mux_high_oe;
      low_output_pin_oe  <= mux_low_oe;
      duty_value_one     <= duty_one_ff;
      duty_value_two     <= duty_two_ff;
    end
  end

  // Read mux; unused upper bits read as zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = !mapped(paddr);
    if (hit(paddr, PPD_OFF_PIN_CTRL))
      nxt_prdata[11:0] = {pair_mode_select_ff, high_pin_enable_ff,
                          low_pin_enable_ff};
    else if (hit(paddr, PPD_OFF_DUTY_ONE))
      nxt_prdata[15:0] = duty_one_ff;
    else if (hit(paddr, PPD_OFF_DUTY_TWO))
      nxt_prdata[15:0] = duty_two_ff;
    else if (hit(paddr, PPD_OFF_PIN_DRIVE))
      nxt_prdata[7:0] = {drive_high_ff, drive_low_ff};
  end

  // Zero wait states: ready is registered high in the access cycle when clk_en is high at the edge ending setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= setup_phase;
      pslverr <= setup_phase && nxt_slverr;
      // Writes and unmapped reads return zero, never stale data
      if (setup_phase)
        prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
      else if (!psel)
        prdata <= 32'h0000_0000;
    end
  end
endmodule // ppd_pwm_pin_pair_duty_control
`default_nettype wire

// >>> ppd_properties.sv
/* Port checker for the pin-pair slice.
   Assumes clk_en high throughout the run. */
`timescale 1ns/1ps
`default_nettype none
module ppd_properties
  import ppd_pkg::*;
#(parameter int unsigned NUM_PAIRS = 4) (
  // Watched ports
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [31:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 pin_ownership_fuse,
  input wire logic [NUM_PAIRS-1:0] high_output_pin_oe,
  input wire logic [NUM_PAIRS-1:0] low_output_pin_oe,
  input wire logic [15:0]          duty_value_one,
  input wire logic [15:0]          duty_value_two
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A write is its setup cycle, then the access cycle with ready
  sequence s_wr(logic [31:0] a, logic [3:0] m);
    (psel && !penable && pwrite && paddr == a && (pstrb & m) == m)
    ##1 (psel && penable && pready);
  endsequence
  a_ready_after: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_unmap: assert property (pready |->
    pslverr == !(paddr inside {32'h0, 32'h4, 32'h8, 32'hC}))
    else $error("wrong error flag");
  a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("data on error");
  a_fuse_load: assert property ($rose(presetn) |-> ##2
    {high_output_pin_oe, low_output_pin_oe} ==
    {(2*NUM_PAIRS){pin_ownership_fuse}}) else $error("fuse not loaded");
  a_oe_follow: assert property (s_wr(32'h0, 4'h1) |-> ##2
    {high_output_pin_oe, low_output_pin_oe} ==
    $past(pwdata[2*NUM_PAIRS-1:0], 2)) else $error("enables wrong");
  a_duty_one: assert property (s_wr(32'h4, 4'h3) |-> ##2
    duty_value_one == $past(pwdata[15:0], 2)) else $error("duty one");
  a_duty_two: assert property ($changed(duty_value_two) |->
    $past(psel && penable && pready && pwrite && paddr == 32'h8, 2))
    else $error("duty two moved");
endmodule // ppd_properties
bind ppd_pwm_pin_pair_duty_control ppd_properties #(
  .NUM_PAIRS(NUM_PAIRS)) i_ppd_properties (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .pin_ownership_fuse, .high_output_pin_oe, .low_output_pin_oe,
  .duty_value_one, .duty_value_two);
`default_nettype wire

// >>> ppd_stage.sv
/* Power stage model: gate levels seen past the pins.
   Assumes pull-downs on gate inputs of released pins. */
`timescale 1ns/1ps
`default_nettype none
module ppd_stage (
  // Pins from the block
  input  wire logic [3:0] high_pin,
  input  wire logic [3:0] low_pin,
  input  wire logic [3:0] high_oe,
  input  wire logic [3:0] low_oe,
  // Gate levels
  output logic      [3:0] high_gate,
  output logic      [3:0] low_gate
);
  // Released pin falls to the pull-down, never a stale level
  assign high_gate = high_oe & high_pin;
  assign low_gate  = low_oe & low_pin;
endmodule // ppd_stage
`default_nettype wire

// >>> tb_pwm_pin_pair_duty_control.sv
/* Bench for the pin-pair and duty slice over APB.
   Assumes writes land at the access edge and pins follow one edge later. */
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_pin_pair_duty_control;
  import ppd_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic fuse = 1, pready, pslverr, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic [3:0] hp, lp, ho, lo, hg, lg, e;
  logic [15:0] d1, d2;
  logic [3:0] strb = 4'hF;
  int n_errors = 0, cmp_count = 0;
  always #10 pclk = ~pclk;
  ppd_pwm_pin_pair_duty_control i_ppd_pwm_pin_pair_duty_control (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(strb), .prdata, .pready, .pslverr,
    .pin_ownership_fuse(fuse), .high_output_pin(hp), .low_output_pin(lp),
    .high_output_pin_oe(ho), .low_output_pin_oe(lo),
    .duty_value_one(d1), .duty_value_two(d2));
  ppd_stage i_ppd_stage (.high_pin(hp), .low_pin(lp), .high_oe(ho),
    .low_oe(lo), .high_gate(hg), .low_gate(lg));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t: no ready from the slave", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Enables take the fuse level on the first edge after release
  task t_reset(input logic f);
    presetn <= 0;
    fuse <= f;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, 32'h0, 0);
    chk(rd, {20'h0, PPD_MODE_RESET, {8{f}}});
    chk({ho, lo}, {8{f}});
    apb(0, 32'h4, 0);
    chk(rd, 0);
    apb(0, 32'h8, 0);
    chk(rd, 0);
  endtask
  task t_duty;
    apb(1, 32'h4, 32'hFFFF_A5C3);
    apb(1, 32'h8, 32'h0000_5A3C);
    apb(0, 32'h4, 0);
    chk(rd, 32'h0000_A5C3);
    chk(d1, 16'hA5C3);
    chk(d2, 16'h5A3C);
  endtask
  task t_pairs;
    apb(1, 32'hC, 32'h0000_0053);
    for (int m = 0; m < 16; m++) begin
      apb(1, 32'h0, {20'h0, m[3:0], 8'h5A});
      repeat (2) @(posedge pclk);
      e = (m[3:0] & 4'h3) | (~m[3:0] & 4'hA);
      chk(hp, 4'h5);
      chk(lp, e);
      chk({ho, lo}, 8'h5A);
      chk({hg, lg}, {4'h5, e & 4'hA});
    end
  endtask
  task t_unmapped;
    apb(1, 32'h10, 32'hFFFF_FFFF);
    chk(err, 1);
    apb(0, 32'h10, 0);
    chk(err, 1);
    chk(rd, 0);
    apb(0, 32'h4, 0);
    chk(rd, 32'hA5C3);
  endtask
  // Byte strobes: only the enabled bytes of a register may change
  task t_strobe;
    strb <= 4'h1;
    apb(1, 32'h4, 32'h0000_1234);
    strb <= 4'h2;
    apb(1, 32'h4, 32'h0000_7799);
    apb(1, 32'h0, 32'h0000_0300);
    strb <= 4'h1;
    apb(1, 32'h0, 32'h0000_0C96);
    strb <= 4'hF;
    apb(0, 32'h4, 0);
    chk(rd, 32'h0000_7734);
    apb(0, 32'h0, 0);
    chk(rd, 32'h0000_0396);
  endtask
  task conclude;
    $display("Errors %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_reset(1);
    t_duty;
    t_pairs;
    t_unmapped;
    t_strobe;
    t_reset(0);
    conclude;
  end
  // Whole run needs about 140 cycles
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
endmodule // tb_pwm_pin_pair_duty_control
`default_nettype wire
